//--- inc/fpau_regs.svh
/*
  Register offsets, field positions, codes and format constants of the
  floating-point unit. Assumes inclusion by every file that needs them.
*/
`ifndef FPAU_REGS_SVH
`define FPAU_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FPAU_CTRL_OFS 8'h00
`define FPAU_STAT_OFS 8'h04
`define FPAU_ERRC_OFS 8'h08
`define FPAU_SRCA_OFS 8'h10
`define FPAU_SRCB_OFS 8'h20
`define FPAU_DEST_OFS 8'h30

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FPAU_CTRL_EN 0
`define FPAU_CTRL_OP_LO 1
`define FPAU_CTRL_OP_HI 2
`define FPAU_CTRL_DBL 3
`define FPAU_CTRL_PULSE 4
`define FPAU_CTRL_RST 5'h00
`define FPAU_STAT_ZERO 0
`define FPAU_STAT_ERR 1
`define FPAU_ERR_RANGE 16'h2013

// ----------------------------------------
// Substitute patterns and formats
// ----------------------------------------
`define FPAU_SGL_UNDER 64'h0000_0000_0ff7_ffff
`define FPAU_SGL_OVER 64'h0000_0000_07f7_ffff
`define FPAU_DBL_UNDER 64'h0000_ffef_ffff_ffff
`define FPAU_DBL_OVER 64'h0000_7fef_ffff_ffff
`define FPAU_SGL_BIAS 14'sh007f
`define FPAU_DBL_BIAS 14'sh03ff
`define FPAU_SGL_EMAX 14'sh00ff
`define FPAU_DBL_EMAX 14'sh07ff

`endif

//--- inc/fpau_pkg.sv
/*
  Types of the floating-point unit: operations and sequencer states.
  Assumes nothing of its surroundings.
*/
package fpau_pkg;
  typedef enum logic [1:0] {FPAU_ADD, FPAU_SUB, FPAU_MUL, FPAU_NOP} fpau_op_t;
  typedef enum {FPAU_IDLE, FPAU_CALC} fpau_state_t;
endpackage

//--- rtl/fpau_unpack.sv
/*
  Splits a single or double operand into sign, exponent and mantissa.
  Assumes the raw word holds a single operand in its low 32 bits.
*/
`timescale 1ns/1ps
`include "fpau_regs.svh"

module fpau_unpack (
  // Raw operand
  input wire logic [63:0] word,
  input wire logic dbl,
  // Unpacked fields
  output logic sign,
  output logic signed [13:0] exp,
  output logic [52:0] man,
  output logic zero,
  output logic bad
);
  always_comb begin
    if (dbl) begin
      sign = word[63];
      exp = $signed({3'b000, word[62:52]}) - `FPAU_DBL_BIAS;
      zero = (word[62:52] == 11'h000);
      bad = (word[62:52] == 11'h7ff);
      man = {1'b1, word[51:0]};
    end else begin
      sign = word[31];
      exp = $signed({6'h00, word[30:23]}) - `FPAU_SGL_BIAS;
      zero = (word[30:23] == 8'h00);
      bad = (word[30:23] == 8'hff);
      man = {1'b1, word[22:0], 29'h0};
    end
    if (zero) begin
      man = 53'h0;
    end
  end
endmodule

//--- rtl/fpau_pack.sv
/*
  Truncates a normalised result toward zero and packs it.
  Assumes the mantissa has its leading one at bit 55 unless zero.
*/
`timescale 1ns/1ps
`include "fpau_regs.svh"

module fpau_pack (
  // Unrounded result
  input wire logic sign,
  input wire logic signed [13:0] exp,
  input wire logic [55:0] man,
  input wire logic zero,
  input wire logic dbl,
  // Packed result
  output logic [63:0] word,
  output logic under,
  output logic over
);
  logic signed [13:0] bexp;

  // Round toward zero: bits below the kept mantissa are dropped
  always_comb begin
    if (dbl) begin
      bexp = exp + `FPAU_DBL_BIAS;
      over = ~zero && (bexp >= `FPAU_DBL_EMAX);
      under = ~zero && (bexp <= 14'sh0000);
      word = {sign, bexp[10:0], man[54:3]};
      if (over) begin
        word = `FPAU_DBL_OVER;
      end else if (under) begin
        word = `FPAU_DBL_UNDER;
      end
    end else begin
      bexp = exp + `FPAU_SGL_BIAS;
      over = ~zero && (bexp >= `FPAU_SGL_EMAX);
      under = ~zero && (bexp <= 14'sh0000);
      word = {32'h0, sign, bexp[7:0], man[54:32]};
      if (over) begin
        word = `FPAU_SGL_OVER;
      end else if (under) begin
        word = `FPAU_SGL_UNDER;
      end
    end
    if (zero) begin
      word = 64'h0;
    end
  end
endmodule

//--- rtl/fpau_top.sv
/*
  Floating-point add, subtract and multiply unit behind an APB slave.
  Assumes one clock, an APB master, and operands held in 16-bit words.
*/
`timescale 1ns/1ps
`include "fpau_regs.svh"

// Contract
// - Add writes first plus second operand
// - Subtract writes first minus second operand
// - Multiply writes first times second operand
// - Single and double formats behave alike
// - Zero result sets zero flag
// - Underflow writes fixed substitute pattern
// - Overflow writes fixed saturation pattern
// - Bad operand: no execution, error flag, code
// - Operands use binary floating-point encoding
// - Upper word sits at higher address
module fpau_top
  import fpau_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Condition flags
  output logic zeroResultFlag,
  output logic operationErrorFlag
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [4:0] ctrl;
  logic [15:0] srcA [4];
  logic [15:0] srcB [4];
  logic [15:0] dest [4];
  logic [15:0] errCode;
  logic enPrev;
  logic pend;
  logic enEdge;
  logic fire;
  fpau_state_t state;
  logic wrEn;
  logic rdSetup;
  logic stWr;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [1:0] wIdx;
  logic [7:0] bankBase;
  logic [63:0] opA;
  logic [63:0] opB;
  logic uaS, ubS, uaZ, ubZ, uaB, ubB;
  logic signed [13:0] uaE, ubE;
  logic [52:0] uaM, ubM;
  fpau_op_t op;
  logic dbl;
  logic aS, bS, aZ, bZ, bad;
  logic signed [13:0] aE, bE;
  logic [52:0] aM, bM;
  logic calcOk;
  logic effS, swap, bigS, smlS, resS, resZ, under, over;
  logic signed [13:0] bigE, smlE, dE, resE;
  logic [55:0] bigW, smlW, alg;
  logic [56:0] sum;
  logic [105:0] prod;
  logic [55:0] resM;
  logic [5:0] lz;
  logic [63:0] resWord;

  function automatic logic [5:0] lead0(input logic [55:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 56; i++) begin
      if (v[i]) begin
        n = 6'(55 - i);
      end
    end
    return n;
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wIdx = paddr[3:2];
  assign bankBase = {paddr[7:4], 2'b00, paddr[1:0]};
  assign wrEn = psel & penable & pwrite & pready;
  assign rdSetup = psel & ~penable;
  assign stWr = wrEn && (paddr == `FPAU_STAT_OFS);

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr == `FPAU_CTRL_OFS) begin
      next_prdata = {27'h0, ctrl};
    end else if (paddr == `FPAU_STAT_OFS) begin
      next_prdata = {30'h0, operationErrorFlag, zeroResultFlag};
    end else if (paddr == `FPAU_ERRC_OFS) begin
      next_prdata = {16'h0, errCode};
    end else if (bankBase == `FPAU_SRCA_OFS) begin
      next_prdata = {16'h0, srcA[wIdx]};
    end else if (bankBase == `FPAU_SRCB_OFS) begin
      next_prdata = {16'h0, srcB[wIdx]};
    end else if (bankBase == `FPAU_DEST_OFS) begin
      next_prdata = {16'h0, dest[wIdx]};
    end else begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rdSetup;
      pslverr <= rdSetup & next_pslverr;
      if (rdSetup & ~pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `FPAU_CTRL_RST;
    end else if (wrEn && (paddr == `FPAU_CTRL_OFS)) begin
      ctrl <= pwdata[4:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        srcA[i] <= 16'h0000;
        srcB[i] <= 16'h0000;
      end
    end else if (wrEn && (bankBase == `FPAU_SRCA_OFS)) begin
      srcA[wIdx] <= pwdata[15:0];
    end else if (wrEn && (bankBase == `FPAU_SRCB_OFS)) begin
      srcB[wIdx] <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  assign enEdge = ctrl[`FPAU_CTRL_EN] & ~enPrev;
  assign fire = (state == FPAU_IDLE) && ctrl[`FPAU_CTRL_EN]
    && (ctrl[`FPAU_CTRL_OP_HI:`FPAU_CTRL_OP_LO] != 2'h3)
    && (!ctrl[`FPAU_CTRL_PULSE] || enEdge || pend);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      enPrev <= 1'b0;
    end else begin
      enPrev <= ctrl[`FPAU_CTRL_EN];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
    end else if (enEdge && (state != FPAU_IDLE)) begin
      pend <= 1'b1;
    end else if (state == FPAU_IDLE) begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= FPAU_IDLE;
    end else begin
      case (state)
        FPAU_IDLE: begin
          if (fire) begin
            state <= FPAU_CALC;
          end
        end
        default: begin
          state <= FPAU_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Operand capture
  // ----------------------------------------
  // High word at higher address
  assign opA = {srcA[3], srcA[2], srcA[1], srcA[0]};
  assign opB = {srcB[3], srcB[2], srcB[1], srcB[0]};

  fpau_unpack uA (
    .word(opA),
    .dbl(ctrl[`FPAU_CTRL_DBL]),
    .sign(uaS),
    .exp(uaE),
    .man(uaM),
    .zero(uaZ),
    .bad(uaB)
  );

  fpau_unpack uB (
    .word(opB),
    .dbl(ctrl[`FPAU_CTRL_DBL]),
    .sign(ubS),
    .exp(ubE),
    .man(ubM),
    .zero(ubZ),
    .bad(ubB)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {aS, bS, aZ, bZ, bad, dbl} <= 6'h00;
      aE <= 14'sh0000;
      bE <= 14'sh0000;
      aM <= 53'h0;
      bM <= 53'h0;
      op <= FPAU_ADD;
    end else if (fire) begin
      {aS, bS, aZ, bZ} <= {uaS, ubS, uaZ, ubZ};
      bad <= uaB | ubB;
      dbl <= ctrl[`FPAU_CTRL_DBL];
      aE <= uaE;
      bE <= ubE;
      aM <= uaM;
      bM <= ubM;
      op <= fpau_op_t'(ctrl[`FPAU_CTRL_OP_HI:`FPAU_CTRL_OP_LO]);
    end
  end

  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  always_comb begin
    effS = bS ^ (op == FPAU_SUB);
    swap = (bE > aE) || ((bE == aE) && (bM > aM));
    bigS = swap ? effS : aS;
    smlS = swap ? aS : effS;
    bigE = swap ? bE : aE;
    smlE = swap ? aE : bE;
    bigW = {(swap ? bM : aM), 3'b000};
    smlW = {(swap ? aM : bM), 3'b000};
    dE = bigE - smlE;
    alg = smlW >> $unsigned(dE);
    alg[0] = alg[0] | (|(smlW & ~({56{1'b1}} << $unsigned(dE))));
    if (bigS == smlS) begin
      sum = {1'b0, bigW} + {1'b0, alg};
    end else begin
      sum = {1'b0, bigW} - {1'b0, alg};
    end
    lz = lead0(sum[55:0]);
    prod = aM * bM;
    if (op == FPAU_MUL) begin
      resS = aS ^ bS;
      resZ = aZ | bZ;
      if (prod[105]) begin
        resM = {prod[105:51], |prod[50:0]};
        resE = aE + bE + 14'sh0001;
      end else begin
        resM = {prod[104:50], |prod[49:0]};
        resE = aE + bE;
      end
    end else begin
      resS = bigS;
      resZ = (sum == 57'h0);
      if (sum[56]) begin
        resM = {sum[56:2], |sum[1:0]};
        resE = bigE + 14'sh0001;
      end else begin
        resM = sum[55:0] << lz;
        resE = bigE - $signed({8'h00, lz});
      end
    end
  end

  fpau_pack uPack (
    .sign(resS),
    .exp(resE),
    .man(resM),
    .zero(resZ),
    .dbl(dbl),
    .word(resWord),
    .under(under),
    .over(over)
  );

  // ----------------------------------------
  // Destination and flags
  // ----------------------------------------
  assign calcOk = (state == FPAU_CALC) && !bad;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        dest[i] <= 16'h0000;
      end
    end else if (calcOk) begin
      dest[0] <= resWord[15:0];
      dest[1] <= resWord[31:16];
      if (dbl) begin
        dest[2] <= resWord[47:32];
        dest[3] <= resWord[63:48];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      zeroResultFlag <= 1'b0;
    end else if (calcOk && resZ) begin
      zeroResultFlag <= 1'b1;
    end else if (stWr && pwdata[`FPAU_STAT_ZERO]) begin
      zeroResultFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      operationErrorFlag <= 1'b0;
      errCode <= 16'h0000;
    end else if ((state == FPAU_CALC) && bad) begin
      operationErrorFlag <= 1'b1;
      errCode <= `FPAU_ERR_RANGE;
    end else if (stWr && pwdata[`FPAU_STAT_ERR]) begin
      operationErrorFlag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Sum reaches destination
  a_add_result: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    calcOk && (op == FPAU_ADD) && !dbl
    |=> {dest[1], dest[0]} == $past(resWord[31:0]))
    else $error("add result not written");

  a_sub_result: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    calcOk && (op == FPAU_SUB) && dbl
    |=> {dest[3], dest[2], dest[1], dest[0]} == $past(resWord))
    else $error("sub result not written");

  a_mul_zero: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    calcOk && (op == FPAU_MUL) && (aZ || bZ)
    |=> zeroResultFlag && ({dest[1], dest[0]} == 32'h0))
    else $error("zero factor did not give zero");

  a_sgl_upper: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state == FPAU_CALC) && !dbl
    |=> $stable(dest[2]) && $stable(dest[3]))
    else $error("single op touched upper words");

  a_zero_flag: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    calcOk && resZ |=> zeroResultFlag)
    else $error("zero flag not raised");

  a_under_pattern: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    calcOk && dbl && under
    |=> {dest[3], dest[2], dest[1], dest[0]} == `FPAU_DBL_UNDER)
    else $error("underflow pattern wrong");

  a_over_pattern: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    calcOk && !dbl && over
    |=> {dest[1], dest[0]} == 32'(`FPAU_SGL_OVER))
    else $error("overflow pattern wrong");

  a_range_error: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state == FPAU_CALC) && bad
    |=> operationErrorFlag && (errCode == `FPAU_ERR_RANGE)
      && $stable(dest[0]) && $stable(dest[1]))
    else $error("bad operand not handled");

  a_idle_off: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state == FPAU_IDLE) && !ctrl[`FPAU_CTRL_EN]
    |=> (state == FPAU_IDLE) && $stable(dest[0]))
    else $error("started while disabled");

  a_pulse_once: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state == FPAU_IDLE) && ctrl[`FPAU_CTRL_PULSE] && enPrev
      && ctrl[`FPAU_CTRL_EN] && !pend
    |=> state == FPAU_IDLE)
    else $error("pulse mode retriggered");
endmodule

//--- test/fpau_seq_model.sv
/*
  Sequencer model: APB master that loads operands, sets the enable and
  collects results. Assumes the unit's APB slave on the same clock.
*/
`timescale 1ns/1ps

module fpau_seq_model (
  // Clock
  input wire logic clk_sys,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Hang report
  output logic hang
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hang = 1'b0;
  end

  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] addr,
    input logic [31:0] wd, output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      hang <= 1'b1;
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apbWrite(input logic [7:0] addr, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    xfer(1'b1, addr, wd, d, e);
  endtask

  task automatic apbRead(input logic [7:0] addr, output logic [31:0] d,
    output logic e);
    xfer(1'b0, addr, 32'h0, d, e);
  endtask

  // ----------------------------------------
  // Operand words
  // ----------------------------------------
  // Upper word higher
  task automatic putOperand(input logic [7:0] base, input logic [63:0] v);
    for (int i = 0; i < 4; i++) begin
      apbWrite(base + 8'(4 * i), {16'h0, v[16*i +: 16]});
    end
  endtask

  task automatic getResult(output logic [63:0] v);
    logic [31:0] d;
    logic e;
    for (int i = 0; i < 4; i++) begin
      apbRead(8'h30 + 8'(4 * i), d, e);
      v[16*i +: 16] = d[15:0];
    end
  endtask

  task automatic runHeld(input logic [4:0] ctrl);
    apbWrite(8'h00, {27'h0, ctrl});
    repeat (2) @(posedge clk_sys);
    apbWrite(8'h00, 32'h0);
  endtask
endmodule

//--- test/tb_top.sv
/*
  Testbench of the floating-point unit: arithmetic, substitutes, errors,
  enable handling and the register bus. Assumes the sequencer model.
*/
`timescale 1ns/1ps

module tb_top;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, hang;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic zeroResultFlag, operationErrorFlag;
  int errors = 0;
  int total_checks = 0;

  fpau_top dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zeroResultFlag(zeroResultFlag),
    .operationErrorFlag(operationErrorFlag));

  fpau_seq_model seq (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hang(hang));

  // ----------------------------------------
  // Clock, checks and verdict
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [63:0] seen,
    input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge hang) begin
    errors++;
    summarize();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic runCase(input string name, input logic [4:0] ctrl,
    input logic [63:0] a, b, exp, input logic zero);
    logic [63:0] r;
    seq.apbWrite(8'h04, 32'h3);
    seq.putOperand(8'h10, a);
    seq.putOperand(8'h20, b);
    seq.runHeld(ctrl);
    seq.getResult(r);
    check(name, ctrl[3] ? r : {32'h0, r[31:0]}, exp);
    check("zero flag", zeroResultFlag, zero);
  endtask

  task automatic testBus();
    logic [31:0] d;
    logic e;
    for (int i = 0; i < 3; i++) begin
      seq.apbRead(8'(4 * i), d, e);
      check("reset reg", d, 64'h0);
      check("reset err", e, 64'h0);
    end
    seq.apbWrite(8'h00, 32'h10);
    seq.apbRead(8'h00, d, e);
    check("ctrl readback", d, 32'h10);
    seq.apbWrite(8'h00, 32'h0);
    seq.apbRead(8'h40, d, e);
    check("unmapped err", e, 1'b1);
    check("unmapped data", d, 64'h0);
  endtask

  task automatic testArith();
    runCase("add sgl", 5'h01, 64'h3fb9999a, 64'h4046b852, 64'h4091c28f,
      1'b0);
    runCase("add dbl", 5'h09, 64'h3ff7333333333333, 64'h4008d70a3d70a3d7,
      64'h40123851eb851eb8, 1'b0);
    runCase("sub sgl", 5'h03, 64'h40400000, 64'h3f800000, 64'h40000000,
      1'b0);
    runCase("sub dbl", 5'h0b, 64'h4008000000000000, 64'h4008000000000000,
      64'h0, 1'b1);
    runCase("mul sgl", 5'h05, 64'h40400000, 64'h40000000, 64'h40c00000,
      1'b0);
    runCase("mul dbl", 5'h0d, 64'h4000000000000000, 64'h4008000000000000,
      64'h4018000000000000, 1'b0);
    runCase("add zero", 5'h01, 64'h3f800000, 64'hbf800000, 64'h0,
      1'b1);
    runCase("mul zero", 5'h05, 64'h0, 64'h40000000, 64'h0,
      1'b1);
  endtask

  task automatic testRange();
    runCase("over sgl", 5'h05, 64'h7f7fffff, 64'h40000000, 64'h07f7ffff,
      1'b0);
    runCase("over dbl", 5'h0d, 64'h7fefffffffffffff, 64'h4000000000000000,
      64'h00007fefffffffff, 1'b0);
    runCase("under sgl", 5'h05, 64'h00800000, 64'h3f000000, 64'h0ff7ffff,
      1'b0);
    runCase("under dbl", 5'h0d, 64'h0010000000000000, 64'h3fe0000000000000,
      64'h0000ffefffffffff, 1'b0);
  endtask

  task automatic testError();
    logic [63:0] r;
    logic [31:0] d;
    logic e;
    seq.apbWrite(8'h04, 32'h3);
    seq.putOperand(8'h10, 64'h7f800000);
    seq.putOperand(8'h20, 64'h3f800000);
    seq.runHeld(5'h01);
    seq.getResult(r);
    check("error dest", r, 64'h0000ffefffffffff);
    check("error flag", operationErrorFlag, 1'b1);
    seq.apbRead(8'h08, d, e);
    check("error code", d[15:0], 16'h2013);
    seq.apbRead(8'h04, d, e);
    check("error stat", d[1:0], 2'b10);
  endtask

  task automatic testEnable();
    logic [63:0] r;
    seq.putOperand(8'h10, 64'h3f800000);
    seq.putOperand(8'h20, 64'h3f800000);
    seq.apbWrite(8'h00, 32'h04);
    repeat (6) @(posedge clk_sys);
    seq.getResult(r);
    check("disabled dest", r, 64'h0000ffefffffffff);
    seq.apbWrite(8'h00, 32'h07);
    repeat (6) @(posedge clk_sys);
    seq.getResult(r);
    check("no-op dest", r, 64'h0000ffefffffffff);
    seq.apbWrite(8'h00, 32'h0);
  endtask

  task automatic testPulse();
    logic [63:0] r;
    seq.apbWrite(8'h00, 32'h11);
    repeat (2) @(posedge clk_sys);
    seq.getResult(r);
    check("pulse first", r[31:0], 32'h40000000);
    seq.putOperand(8'h10, 64'h40000000);
    repeat (4) @(posedge clk_sys);
    seq.getResult(r);
    check("pulse held", r[31:0], 32'h40000000);
    seq.apbWrite(8'h00, 32'h10);
    seq.apbWrite(8'h00, 32'h11);
    repeat (2) @(posedge clk_sys);
    seq.getResult(r);
    check("pulse again", r[31:0], 32'h40400000);
    seq.apbWrite(8'h00, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    testBus();
    testArith();
    testRange();
    testError();
    testEnable();
    testPulse();
    summarize();
  end
endmodule
